// [common/nhp_if.sv]
/*
  Valid/ready stream carrying one received byte and its select flag.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface nhp_if #(parameter int unsigned W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [common/nhp_pkg.sv]
/*
  Shared constants for the nibble host port and common scanner: register
  map, instruction fields, scan duty figures and reset values.
  Assumes a 32-bit AHB-Lite register bus decoding the low address byte.
*/
// Summary of operation
// - Bus width chosen only by instruction, never pin.
// - Nibble mode uses only the upper data lines.
// - Byte completes after two nibble transfers.
// - Status read also takes two nibble strobes.
// - Scan 8, 11 or 16 commons per configuration.
// - Two lines only with the 5x8 font.
// - Five segments per character position, 40 total.
// - Every cell includes a cursor row.
// - Instruction selects lines and font for scanning.
// - Width bit 0 nibbles, 1 full bytes.
// - Line-count bit 1 two lines, 0 one.
// - Font bit 0 5x8, 1 5x10.
// - Status top bit is busy; busy refuses writes.
package nhp_pkg;
  localparam int unsigned SYNC_W = 11;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RXDATA = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_SEGLO  = 8'h10;
  localparam logic [7:0] OFF_SEGHI  = 8'h14;
  localparam logic [7:0] OFF_SCAN   = 8'h18;
  // Configuration instruction layout.
  localparam logic [2:0] FS_OPCODE = 3'h1;
  localparam int unsigned FS_OP_LSB = 5;
  localparam int unsigned FS_WIDTH  = 4;
  localparam int unsigned FS_LINES  = 3;
  localparam int unsigned FS_FONT   = 2;
  localparam int unsigned BUSY_BIT  = 7;
  localparam int unsigned RX_VALID_BIT = 31;
  // Common counts per configuration, each including the cursor row.
  localparam logic [4:0] NCOM_1L_5X8  = 5'h08;
  localparam logic [4:0] NCOM_1L_5X10 = 5'h0B;
  localparam logic [4:0] NCOM_2L_5X8  = 5'h10;
  localparam int unsigned SEG_N  = 40;
  localparam int unsigned COM_N  = 16;
  // Reset leaves the port in full-byte mode, one line, 5x8.
  localparam logic RST_WIDTH8 = 1'b1;
  localparam logic RST_LINES2 = 1'b0;
  localparam logic RST_FONT10 = 1'b0;
  localparam logic [7:0] OE_UPPER = 8'hF0;
  localparam logic [7:0] OE_ALL   = 8'hFF;
endpackage

// [hw/nhp_buf.sv]
/*
  Small FIFO between the host port and the register bus.
  Assumes one clock and a power-of-two depth.
*/
`timescale 1ns/1ns
`default_nettype none
module nhp_buf #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Streams
  nhp_if.snk        wr,
  nhp_if.src        rd
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("nhp_buf depth must be a power of two of at least two");
  end

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr;
  logic [AW-1:0] rptr_ff, nxt_rptr;
  logic [AW:0]   cnt_ff,  nxt_cnt;
  logic          push, pop;

  assign wr.ready = (cnt_ff < (AW + 1)'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data  = mem_ff[rptr_ff];

  always_comb
  begin
    push     = wr.valid & wr.ready;
    pop      = rd.valid & rd.ready;
    nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
    nxt_rptr = pop ? rptr_ff + 1'b1 : rptr_ff;
    nxt_cnt  = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end
    else
    begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Storage needs no reset; entries are only read once counted.
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_ff[wptr_ff] <= wr.data;
    end
  end
endmodule // nhp_buf
`default_nettype wire

// [hw/nhp_scan.sv]
/*
  Common-line scanner: steps one active common per slot tick.
  Assumes the slot tick is a one-cycle enable on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module nhp_scan (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        slot_tick,
  input  wire logic [4:0]  ncom,
  // Scan state
  output logic      [3:0]  com_idx_ff,
  output logic      [15:0] com_out_ff
);
  logic [3:0]  nxt_idx;
  logic [15:0] nxt_com;
  logic [4:0]  last;

  always_comb
  begin
    last    = ncom - 5'h01;
    nxt_idx = com_idx_ff;
    if ({1'b0, com_idx_ff} >= last)
    begin
      nxt_idx = slot_tick ? 4'h0 : (({1'b0, com_idx_ff} > last) ? 4'h0 : com_idx_ff);
    end
    else if (slot_tick)
    begin
      nxt_idx = com_idx_ff + 4'h1;
    end
    nxt_com = 16'h0001 << nxt_idx;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      com_idx_ff <= 4'h0;
      com_out_ff <= 16'h0001;
    end
    else
    begin
      com_idx_ff <= nxt_idx;
      com_out_ff <= nxt_com;
    end
  end
endmodule // nhp_scan
`default_nettype wire

// [hw/nhp_top.sv]
/*
  Nibble/byte host port with configuration decode, receive buffer,
  AHB-Lite register slave and common scanning.
  Assumes the host strobe pins are asynchronous and the AHB master is
  the only one on the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module nhp_top #(
  parameter int unsigned SLOT_CYCLES = 1000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Host pins
  input  wire logic        register_select_strobe,
  input  wire logic        read_write_select,
  input  wire logic        pin_e,
  input  wire logic [7:0]  pin_db_in,
  output logic      [7:0]  pin_db_out,
  output logic      [7:0]  pin_db_oe,
  // Display drive
  output logic      [15:0] com_out,
  output logic      [39:0] seg_out
);
  localparam int unsigned CW = $clog2(SLOT_CYCLES + 1);
  if (SLOT_CYCLES < 2)
  begin : g_bad_slot
    $error("nhp_top slot length must be at least two cycles");
  end

  function automatic logic [4:0] ncom_of(input logic lines2, input logic font10);
    // two lines force the 5x8 font
    if (lines2)
      return nhp_pkg::NCOM_2L_5X8;
    else if (font10)
      return nhp_pkg::NCOM_1L_5X10;
    else
      return nhp_pkg::NCOM_1L_5X8;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [nhp_pkg::SYNC_W-1:0] sy1_ff, sy2_ff;
  logic e_d_ff;
  logic rs_s, rw_s, e_s, e_fall;
  logic [7:0] db_s;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
      e_d_ff <= 1'b0;
    end
    else
    begin
      sy1_ff <= {register_select_strobe, read_write_select, pin_e, pin_db_in};
      sy2_ff <= sy1_ff;
      e_d_ff <= sy2_ff[8];
    end
  end

  assign rs_s   = sy2_ff[10];
  assign rw_s   = sy2_ff[9];
  assign e_s    = sy2_ff[8];
  assign db_s   = sy2_ff[7:0];
  assign e_fall = e_d_ff & ~e_s;

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  nhp_if #(.W(9)) rx_in ();
  nhp_if #(.W(9)) rx_out ();

  nhp_buf #(.W(9), .DEPTH(2)) u_buf (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr      (rx_in),
    .rd      (rx_out)
  );

  // ----------------------------------------------------------------
  // Host port
  // ----------------------------------------------------------------
  logic       bus_width_select_ff, nxt_width8;
  logic       lines2_ff, nxt_lines2;
  logic       font10_ff, nxt_font10;
  logic       phase_ff, nxt_phase;
  logic [3:0] hinib_ff, nxt_hinib;
  logic       busy_ff, nxt_busy;
  logic [6:0] ram_pointer_ff, nxt_ptr;
  logic [7:0] db_out_ff, nxt_db_out;
  logic [7:0] db_oe_ff, nxt_db_oe;
  logic       wr_done, accept, fs, busy_indication;
  logic [7:0] wr_byte, rd_byte;
  logic       wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [7:0] tx_ff, nxt_tx;
  logic       sw_status;

  assign sw_status       = wr_pend_ff && (wr_addr_ff == nhp_pkg::OFF_STATUS);
  // Back-pressure from the buffer shows to the host as busy.
  assign busy_indication = busy_ff | ~rx_in.ready;
  assign rx_in.valid     = accept;
  assign rx_in.data      = {rs_s, wr_byte};

  always_comb
  begin
    nxt_width8 = bus_width_select_ff;
    nxt_lines2 = lines2_ff;
    nxt_font10 = font10_ff;
    nxt_phase  = phase_ff;
    nxt_hinib  = hinib_ff;
    nxt_ptr    = sw_status ? hwdata[6:0] : ram_pointer_ff;
    wr_done    = 1'b0;
    wr_byte    = 8'h00;
    if (e_fall && !rw_s)
    begin
      if (bus_width_select_ff)
      begin
        wr_done = 1'b1;
        wr_byte = db_s;
      end
      else if (!phase_ff)
      begin
        nxt_hinib = db_s[7:4];
        nxt_phase = 1'b1;
      end
      else
      begin
        wr_done   = 1'b1;
        wr_byte   = {hinib_ff, db_s[7:4]};
        nxt_phase = 1'b0;
      end
    end
    if (e_fall && rw_s && !bus_width_select_ff)
    begin
      nxt_phase = ~phase_ff;
    end
    accept = wr_done & ~busy_indication;
    fs = accept && !rs_s
      && (wr_byte[nhp_pkg::FS_OP_LSB +: 3] == nhp_pkg::FS_OPCODE);
    if (fs)
    begin
      nxt_width8 = wr_byte[nhp_pkg::FS_WIDTH];
      nxt_lines2 = wr_byte[nhp_pkg::FS_LINES];
      nxt_font10 = wr_byte[nhp_pkg::FS_FONT];
    end
    // host waits out busy; hardware set wins over clear
    nxt_busy = accept | (sw_status ? hwdata[nhp_pkg::BUSY_BIT] : busy_ff);
    // busy in the top status bit
    rd_byte    = rs_s ? tx_ff : {busy_indication, ram_pointer_ff};
    nxt_db_out = 8'h00;
    nxt_db_oe  = 8'h00;
    if (e_s && rw_s)
    begin
      if (bus_width_select_ff)
      begin
        nxt_db_out = rd_byte;
        nxt_db_oe  = nhp_pkg::OE_ALL;
      end
      // only upper lines driven in nibble mode
      else
      begin
        nxt_db_out = {phase_ff ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
        nxt_db_oe  = nhp_pkg::OE_UPPER;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_width_select_ff <= nhp_pkg::RST_WIDTH8;
      lines2_ff           <= nhp_pkg::RST_LINES2;
      font10_ff           <= nhp_pkg::RST_FONT10;
      phase_ff            <= 1'b0;
      hinib_ff            <= 4'h0;
      busy_ff             <= 1'b0;
      ram_pointer_ff      <= 7'h00;
      db_out_ff           <= 8'h00;
      db_oe_ff            <= 8'h00;
    end
    else
    begin
      bus_width_select_ff <= nxt_width8;
      lines2_ff           <= nxt_lines2;
      font10_ff           <= nxt_font10;
      phase_ff            <= nxt_phase;
      hinib_ff            <= nxt_hinib;
      busy_ff             <= nxt_busy;
      ram_pointer_ff      <= nxt_ptr;
      db_out_ff           <= nxt_db_out;
      db_oe_ff            <= nxt_db_oe;
    end
  end

  assign pin_db_out = db_out_ff;
  assign pin_db_oe  = db_oe_ff;

  // ----------------------------------------------------------------
  // Slot divider and scanner
  // ----------------------------------------------------------------
  logic [CW-1:0] div_ff, nxt_div;
  logic          tick_ff, nxt_tick;
  logic [3:0]    com_idx;
  logic [4:0]    ncom;

  assign ncom = ncom_of(lines2_ff, font10_ff);

  always_comb
  begin
    nxt_tick = (div_ff == CW'(SLOT_CYCLES - 1));
    nxt_div  = nxt_tick ? '0 : div_ff + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  nhp_scan u_scan (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .slot_tick  (tick_ff),
    .ncom       (ncom),
    .com_idx_ff (com_idx),
    .com_out_ff (com_out)
  );

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [31:0] seglo_ff, nxt_seglo;
  logic [7:0]  seghi_ff, nxt_seghi;
  logic        aph;

  always_comb
  begin
    aph          = hsel & hready & htrans[1];
    nxt_wr_pend  = aph & hwrite;
    nxt_wr_addr  = haddr[7:0];
    nxt_hrdata   = 32'h0000_0000;
    nxt_tx       = tx_ff;
    nxt_seglo    = seglo_ff;
    nxt_seghi    = seghi_ff;
    rx_out.ready = 1'b0;
    if (aph && !hwrite)
    begin
      case (haddr[7:0])
        nhp_pkg::OFF_CONFIG: nxt_hrdata[7:0] = {ncom, font10_ff, lines2_ff, bus_width_select_ff};
        nhp_pkg::OFF_STATUS: nxt_hrdata[7:0] = {busy_indication, ram_pointer_ff};
        nhp_pkg::OFF_RXDATA:
        begin
          nxt_hrdata[8:0] = rx_out.data;
          nxt_hrdata[nhp_pkg::RX_VALID_BIT] = rx_out.valid;
          // Reading the word pops it; an empty read returns valid clear.
          rx_out.ready = 1'b1;
        end
        nhp_pkg::OFF_TXDATA: nxt_hrdata[7:0] = tx_ff;
        nhp_pkg::OFF_SEGLO:  nxt_hrdata = seglo_ff;
        nhp_pkg::OFF_SEGHI:  nxt_hrdata[7:0] = seghi_ff;
        nhp_pkg::OFF_SCAN:   nxt_hrdata[3:0] = com_idx;
        default:             nxt_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend_ff)
    begin
      case (wr_addr_ff)
        nhp_pkg::OFF_TXDATA: nxt_tx = hwdata[7:0];
        nhp_pkg::OFF_SEGLO:  nxt_seglo = hwdata;
        nhp_pkg::OFF_SEGHI:  nxt_seghi = hwdata[7:0];
        default:             nxt_tx = tx_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata_ff  <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      tx_ff      <= 8'h00;
      seglo_ff   <= 32'h0000_0000;
      seghi_ff   <= 8'h00;
    end
    else
    begin
      hrdata_ff  <= nxt_hrdata;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      tx_ff      <= nxt_tx;
      seglo_ff   <= nxt_seglo;
      seghi_ff   <= nxt_seghi;
    end
  end

  // Zero wait states and OKAY only, so these stay constant.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  // five segments per position, 40 outputs
  assign seg_out   = {seghi_ff, seglo_ff};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_oe_upper_only: assert property (!bus_width_select_ff |=> pin_db_oe[3:0] == 4'h0)
    else $error("lower data lines driven in nibble mode");
  a_nibble_pair: assert property (rx_in.valid && !bus_width_select_ff |-> phase_ff)
    else $error("byte completed on a single nibble");
  a_busy_refuse: assert property (wr_done && busy_indication |-> !rx_in.valid)
    else $error("write accepted while busy");
  a_busy_after_write: assert property (accept |=> busy_ff)
    else $error("busy not raised after accepted byte");
  a_status_top_bit: assert property (e_s && rw_s && !rs_s && bus_width_select_ff
    |=> pin_db_out[7] == $past(busy_indication) && pin_db_oe == nhp_pkg::OE_ALL)
    else $error("status read lacks busy in top bit");
  a_upper_first: assert property (e_s && rw_s && !bus_width_select_ff && !phase_ff
    |=> pin_db_out[7:4] == $past(rd_byte[7:4]))
    else $error("first read nibble is not the upper one");
  a_width_by_instr: assert property ($changed(bus_width_select_ff) |-> $past(fs))
    else $error("width changed without an instruction");
  a_width_decode: assert property (fs |=> bus_width_select_ff == $past(wr_byte[nhp_pkg::FS_WIDTH]))
    else $error("width bit not applied");
  a_two_line_font: assert property (lines2_ff |-> ncom == nhp_pkg::NCOM_2L_5X8)
    else $error("two lines scanned with other than sixteen commons");
  a_com_range: assert property ({1'b0, com_idx} < ncom ##1 1'b1 |-> $onehot(com_out))
    else $error("common outputs not one-hot in range");
  a_com_step: assert property (tick_ff && ({1'b0, com_idx} < ncom - 5'h01)
    |=> com_idx == $past(com_idx) + 4'h1)
    else $error("common did not advance on slot tick");

  c_nibble_write: cover property (rx_in.valid && !bus_width_select_ff);
  c_nibble_read: cover property (e_fall && rw_s && !bus_width_select_ff && phase_ff);
  c_buffer_full: cover property (!rx_in.ready);
  c_mode_switch: cover property (fs && !wr_byte[4]);
endmodule // nhp_top
`default_nettype wire

// [test/nhp_host.sv]
/*
  Host processor model driving the nibble/byte port pins.
  Assumes the bench resolves the data wire, with pull-ups when undriven.
*/
`timescale 1ns/1ns
`default_nettype none
module nhp_host (
  // Clock
  input  wire logic       ref_clk,
  // Data wire and device enables
  input  wire logic [7:0] dq_i,
  input  wire logic [7:0] oe_i,
  // Host drive
  output logic            rs_o,
  output logic            rw_o,
  output logic            e_o,
  output logic      [7:0] dq_o,
  output logic            dq_oe_o
);
  logic [7:0] oe_seen;

  initial
  begin
    rs_o = 1'b0;
    rw_o = 1'b0;
    e_o = 1'b0;
    dq_o = 8'h00;
    dq_oe_o = 1'b0;
    oe_seen = 8'h00;
  end

  // Five cycles per phase so the device's sync and edge detect always see it.
  task automatic strobe(input logic r, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    rs_o <= r;
    rw_o <= w;
    dq_o <= d;
    dq_oe_o <= ~w;
    @(posedge ref_clk);
    e_o <= 1'b1;
    repeat (5) @(posedge ref_clk);
    q = dq_i;
    oe_seen = oe_i;
    e_o <= 1'b0;
    repeat (5) @(posedge ref_clk);
    dq_oe_o <= 1'b0;
    rw_o <= 1'b0;
    @(posedge ref_clk);
  endtask

  // upper nibble first, or one strobe on a byte port
  task automatic wr(input logic nib, input logic r, input logic [7:0] b);
    logic [7:0] q;
    if (nib)
    begin
      strobe(r, 1'b0, {b[7:4], 4'h5}, q);
      strobe(r, 1'b0, {b[3:0], 4'hA}, q);
    end
    else
      strobe(r, 1'b0, b, q);
  endtask

  // two read strobes make one byte in nibble mode
  task automatic rd(input logic nib, input logic r, output logic [7:0] q);
    logic [7:0] h;
    if (nib)
    begin
      strobe(r, 1'b1, 8'h00, h);
      strobe(r, 1'b1, 8'h00, q);
      q = {h[7:4], q[7:4]};
    end
    else
      strobe(r, 1'b1, 8'h00, q);
  endtask
endmodule // nhp_host
`default_nettype wire

// [test/tb.sv]
/*
  Self-checking bench for the nibble host port and common scanner.
  Assumes a host model on the pins and this bench as AHB-Lite master.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int SLOT = 4;
  logic        ref_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rs;
  logic        rw;
  logic        e;
  logic [7:0]  hdq;
  logic        hoe;
  logic [7:0]  dq;
  logic [7:0]  dout;
  logic [7:0]  doe;
  logic [15:0] com_out;
  logic [39:0] seg_out;
  logic [31:0] q;
  logic [7:0]  b;
  int          failures;
  int          n_tests;

  // Undriven data lines float up to the pull-ups.
  assign dq = hoe ? hdq : ((doe & dout) | ~doe);

  nhp_top #(.SLOT_CYCLES(SLOT)) nhp_top_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .register_select_strobe(rs), .read_write_select(rw), .pin_e(e),
    .pin_db_in(dq), .pin_db_out(dout), .pin_db_oe(doe),
    .com_out(com_out), .seg_out(seg_out));

  nhp_host nhp_host_i (.ref_clk(ref_clk), .dq_i(dq), .oe_i(doe), .rs_o(rs),
    .rw_o(rw), .e_o(e), .dq_o(hdq), .dq_oe_o(hoe));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      chk("hready wait", 1'b0, 1'b1);
      final_report();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask

  task automatic pop(input logic [31:0] x);
    ahb(1'b0, nhp_pkg::OFF_RXDATA, 32'h0);
    chk("rxdata", q, x);
    ahb(1'b1, nhp_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic scan(input logic [4:0] n);
    int k;
    k = 0;
    while (com_out === 16'h1 && k < 100)
    begin
      @(posedge ref_clk);
      k++;
    end
    while (com_out !== 16'h1 && k < 200)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 200)
    begin
      chk("scan wait", 1'b0, 1'b1);
      final_report();
    end
    @(posedge ref_clk);
    for (int i = 0; i < 2 * n; i++)
    begin
      chk("com_out", com_out, 16'h1 << (i % n));
      repeat (SLOT) @(posedge ref_clk);
    end
    ahb(1'b0, nhp_pkg::OFF_SCAN, 32'h0);
    chk("scan index", {4'h0, q[3:0]} < {3'h0, n}, 1'b1);
  endtask

  task automatic t_reset;
    chk("oe", doe, 8'h00);
    chk("hresp", hresp, 1'b0);
    ahb(1'b0, nhp_pkg::OFF_CONFIG, 32'h0);
    chk("config", q, 32'h41);
    ahb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_nibble;
    nhp_host_i.wr(1'b0, 1'b0, 8'h28);
    ahb(1'b0, nhp_pkg::OFF_CONFIG, 32'h0);
    chk("config", q, 32'h82);
    ahb(1'b0, nhp_pkg::OFF_STATUS, 32'h0);
    chk("busy", q[7], 1'b1);
    pop(32'h8000_0028);
    nhp_host_i.strobe(1'b1, 1'b0, 8'hA5, b);
    ahb(1'b0, nhp_pkg::OFF_RXDATA, 32'h0);
    chk("half byte", q[31], 1'b0);
    nhp_host_i.strobe(1'b1, 1'b0, 8'h5F, b);
    pop(32'h8000_01A5);
    ahb(1'b1, nhp_pkg::OFF_TXDATA, 32'h3C);
    nhp_host_i.rd(1'b1, 1'b1, b);
    chk("data read", b, 8'h3C);
    chk("oe", nhp_host_i.oe_seen, nhp_pkg::OE_UPPER);
    ahb(1'b1, nhp_pkg::OFF_STATUS, 32'h80);
    nhp_host_i.rd(1'b1, 1'b0, b);
    chk("status busy", b[7], 1'b1);
    ahb(1'b1, nhp_pkg::OFF_STATUS, 32'h0);
    nhp_host_i.rd(1'b1, 1'b0, b);
    chk("status idle", b[7], 1'b0);
    $display("nibble test done");
  endtask

  task automatic t_config;
    logic [7:0] ins [4] = '{8'h20, 8'h24, 8'h2C, 8'h28};
    logic [4:0] nc [4] = '{nhp_pkg::NCOM_1L_5X8, nhp_pkg::NCOM_1L_5X10,
                          nhp_pkg::NCOM_2L_5X8, nhp_pkg::NCOM_2L_5X8};
    for (int i = 0; i < 4; i++)
    begin
      nhp_host_i.wr(1'b1, 1'b0, ins[i]);
      ahb(1'b0, nhp_pkg::OFF_CONFIG, 32'h0);
      chk("ncom", q[7:3], nc[i]);
      chk("lines", q[1], ins[i][3]);
      if (!ins[i][3])
        chk("font", q[2], ins[i][2]);
      pop({24'h80_0000, ins[i]});
      scan(nc[i]);
    end
    ahb(1'b1, nhp_pkg::OFF_SEGLO, 32'h1234_5678);
    ahb(1'b1, nhp_pkg::OFF_SEGHI, 32'h9A);
    repeat (2) @(posedge ref_clk);
    chk("seg_out", seg_out, 40'h9A_1234_5678);
    $display("config test done");
  endtask

  task automatic t_buffer;
    nhp_host_i.wr(1'b1, 1'b0, 8'h30);
    pop(32'h8000_0030);
    nhp_host_i.rd(1'b0, 1'b1, b);
    chk("byte read", b, 8'h3C);
    chk("oe", nhp_host_i.oe_seen, nhp_pkg::OE_ALL);
    nhp_host_i.wr(1'b0, 1'b1, 8'h11);
    ahb(1'b1, nhp_pkg::OFF_STATUS, 32'h0);
    nhp_host_i.wr(1'b0, 1'b1, 8'h22);
    ahb(1'b1, nhp_pkg::OFF_STATUS, 32'h0);
    ahb(1'b0, nhp_pkg::OFF_STATUS, 32'h0);
    chk("full busy", q[7], 1'b1);
    nhp_host_i.wr(1'b0, 1'b1, 8'h33);
    pop(32'h8000_0111);
    pop(32'h8000_0122);
    ahb(1'b0, nhp_pkg::OFF_RXDATA, 32'h0);
    chk("drained", q[31], 1'b0);
    nhp_host_i.wr(1'b0, 1'b1, 8'h44);
    nhp_host_i.wr(1'b0, 1'b1, 8'h55);
    pop(32'h8000_0144);
    ahb(1'b0, nhp_pkg::OFF_RXDATA, 32'h0);
    chk("busy drop", q[31], 1'b0);
    $display("buffer test done");
  endtask

  initial
  begin
    failures = 0;
    n_tests = 0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_nibble();
    t_config();
    t_buffer();
    final_report();
  end
endmodule // tb
`default_nettype wire
